/* rtl/qdi_pkg.sv */
// Overview of operation
// - one gating bit, bit 9 of clock disable word, stops decoder clock only.
// - after reset the decoder clock domain runs; gating bit resets clear.
// - each decoder raises phase error on an illegal A/B transition.
// - both phase errors feed one selection mux choosing the forwarded source.
// - mux output is inverted and driven to the high-end timer input.
// - every input is double synchronized, optionally filtered per select bits.
// - phase A: bit 0 set gives sync path; bit 0 clear, bit 1 set filtered.
// - phase B: bit 8 set gives sync path; bit 8 clear, bit 9 set filtered.
// - index: bit 16 set gives sync path; bit 16 clear, bit 17 set filtered.
// - strobe: bit 24 set gives sync path; bit 24 clear, bit 25 filtered.
// - position counter increments within 4 cycles of the input edge on the sync path.
// - compare sync output responds within 6 cycles of causing input edge on the sync path.
package qdi_pkg;

  localparam int QDI_CLK_GATE_BIT   = 9;
  localparam int QDI_SEL_A_SYNC     = 0;
  localparam int QDI_SEL_A_FILT     = 1;
  localparam int QDI_SEL_B_SYNC     = 8;
  localparam int QDI_SEL_B_FILT     = 9;
  localparam int QDI_SEL_I_SYNC     = 16;
  localparam int QDI_SEL_I_FILT     = 17;
  localparam int QDI_SEL_S_SYNC     = 24;
  localparam int QDI_SEL_S_FILT     = 25;
  localparam int QDI_MIN_PERIOD_CYC = 2;
  localparam int QDI_CNT_LAT_CYC    = 4;
  localparam int QDI_CMP_LAT_CYC    = 6;
  localparam int QDI_FILT_WIDTH     = 3;
  localparam int QDI_POS_WIDTH      = 32;
  localparam logic [31:0] QDI_CLKDIS_RESET = 32'h0000_0000;
  localparam logic [31:0] QDI_SEL_RESET    = 32'h0101_0101;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index;
    logic strobe;
  } qdi_pins_type;

endpackage : qdi_pkg

/* rtl/qdi_decoder.sv */
`timescale 1ns/1ps
// ****************************************
// quadrature decoder core
// ****************************************
module qdi_decoder
  import qdi_pkg::*;
#(
  parameter int POS_W = QDI_POS_WIDTH
)(
  input  wire logic             clk_in,         // peripheral bus clock
  input  wire logic             srst_in,        // sync reset
  input  wire logic             run_in,         // decoder clock enabled
  input  wire qdi_pins_type     pins_in,        // conditioned inputs
  input  wire logic [POS_W-1:0] cmp_val_in,     // compare value
  output logic [POS_W-1:0]      pos_out,        // position counter
  output logic                  phase_err_out,  // illegal transition
  output logic                  cmp_sync_out,   // compare pulse
  output logic                  index_seen_out, // index latched
  output logic [POS_W-1:0]      strobe_pos_out  // position at strobe
);

  logic [1:0]       ab_q;
  logic             idx_q;
  logic             stb_q;
  logic [1:0]       ab_new;
  logic [1:0]       diff;
  logic             fwd;
  logic [POS_W-1:0] pos_d;

  assign ab_new = {pins_in.phase_a, pins_in.phase_b};
  assign diff   = ab_q ^ ab_new;
  // gray order 00,10,11,01: forward when a_new != b_old
  assign fwd    = ab_new[1] ^ ab_q[0];

  always_comb
  begin
    pos_d = pos_out;
    if (diff == 2'b01 || diff == 2'b10)
    begin
      pos_d = fwd ? pos_out + 1'b1 : pos_out - 1'b1;
    end
  end

  // all updates held by run_in: frozen while gated
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ab_q  <= 2'b00;
      idx_q <= 1'b0;
      stb_q <= 1'b0;
    end
    else if (run_in)
    begin
      ab_q  <= ab_new;
      idx_q <= pins_in.index;
      stb_q <= pins_in.strobe;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      pos_out <= '0;
    else if (run_in)
      pos_out <= pos_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      phase_err_out <= 1'b0;
    else if (run_in && diff == 2'b11)
      phase_err_out <= 1'b1;
    else if (run_in && diff != 2'b00)
      phase_err_out <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      cmp_sync_out <= 1'b0;
    else if (run_in)
      cmp_sync_out <= (pos_d == cmp_val_in) && (pos_d != pos_out);
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      index_seen_out <= 1'b0;
      strobe_pos_out <= '0;
    end
    else if (run_in)
    begin
      if (pins_in.index && !idx_q)
        index_seen_out <= 1'b1;
      if (pins_in.strobe && !stb_q)
        strobe_pos_out <= pos_out;
    end
  end

endmodule : qdi_decoder

/* rtl/qdi_top.sv */
`timescale 1ns/1ps
module qdi_top
  import qdi_pkg::*;
#(
  parameter int POS_W  = QDI_POS_WIDTH,
  parameter int FILT_W = QDI_FILT_WIDTH
)(
  input  wire logic             clk_in,          // peripheral bus clock
  input  wire logic             srst_in,         // sync reset, active high
  input  wire logic [31:0]      clk_dis_in,      // clock domain disable word
  input  wire logic [31:0]      path_sel_in,     // input path select word
  input  wire logic             err_sel_in,      // 0 decoder 0, 1 decoder 1
  input  wire qdi_pins_type     enc0_in,         // encoder 0 pins
  input  wire qdi_pins_type     enc1_in,         // encoder 1 pins
  input  wire logic [POS_W-1:0] cmp0_in,         // decoder 0 compare value
  input  wire logic [POS_W-1:0] cmp1_in,         // decoder 1 compare value
  output logic [POS_W-1:0]      pos0_out,        // decoder 0 position
  output logic [POS_W-1:0]      pos1_out,        // decoder 1 position
  output logic [1:0]            phase_err_out,   // per-decoder phase error
  output logic [1:0]            cmp_sync_out,    // compare sync pulses
  output logic [1:0]            index_seen_out,  // index latched
  output logic [POS_W-1:0]      strobe_pos0_out, // decoder 0 strobe capture
  output logic [POS_W-1:0]      strobe_pos1_out, // decoder 1 strobe capture
  output logic                  timer_err_n_out, // inverted error to timer
  output logic                  dec_run_out      // decoder clock running
);

  // ****************************************
  // clock gating
  // ****************************************
  logic run_q;

  // bit set stops the decoders one edge later
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      run_q <= 1'b1;
    else
      run_q <= ~clk_dis_in[QDI_CLK_GATE_BIT];
  end

  // ****************************************
  // decoder clock status
  // ****************************************
  assign dec_run_out = run_q;

  // ****************************************
  // input conditioning
  // ****************************************
  function automatic logic pick(input logic sync_v, input logic filt_v,
                                input logic b_sync, input logic b_filt,
                                input logic fallback);
    if (b_sync)
      pick = sync_v;
    else if (b_filt)
      pick = filt_v;
    else
      pick = fallback;
  endfunction : pick

  localparam int NIN = 8;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] filt_q;
  logic [NIN-1:0] cond;
  logic [FILT_W-1:0] shr_q [NIN];
  logic [3:0]        use_sync;
  logic [3:0]        use_filt;

  assign raw = {enc1_in, enc0_in};

  // ****************************************
  // two stage synchroniser
  // ****************************************
  // only s2_q is read past this point
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // ****************************************
  // input filter
  // ****************************************
  // sample history, one shift register per input
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < NIN; i++)
        shr_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < NIN; i++)
        shr_q[i] <= {shr_q[i][FILT_W-2:0], s2_q[i]};
    end
  end

  // output follows only after FILT_W equal samples
  // steady input: filt_q equals s2_q, so path switch is clean
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      filt_q <= '0;
    else
    begin
      for (int i = 0; i < NIN; i++)
      begin
        if (&shr_q[i])
          filt_q[i] <= 1'b1;
        else if (~|shr_q[i])
          filt_q[i] <= 1'b0;
      end
    end
  end

  // ****************************************
  // path selection
  // ****************************************
  // select bits in pin order a, b, index, strobe
  // both bits clear falls back to the sync path
  always_comb
  begin
    use_sync[3] = path_sel_in[QDI_SEL_A_SYNC];
    use_filt[3] = path_sel_in[QDI_SEL_A_FILT];
    use_sync[2] = path_sel_in[QDI_SEL_B_SYNC];
    use_filt[2] = path_sel_in[QDI_SEL_B_FILT];
    use_sync[1] = path_sel_in[QDI_SEL_I_SYNC];
    use_filt[1] = path_sel_in[QDI_SEL_I_FILT];
    use_sync[0] = path_sel_in[QDI_SEL_S_SYNC];
    use_filt[0] = path_sel_in[QDI_SEL_S_FILT];
  end

  // packed order per encoder: a, b, index, strobe (msb first)
  // one select word serves both encoders
  generate
    for (genvar e = 0; e < 2; e++)
    begin : g_sel
      localparam int O = e * 4;
      assign cond[O+3] = pick(s2_q[O+3], filt_q[O+3],
        use_sync[3], use_filt[3],
        s2_q[O+3]);
      assign cond[O+2] = pick(s2_q[O+2], filt_q[O+2],
        use_sync[2], use_filt[2],
        s2_q[O+2]);
      assign cond[O+1] = pick(s2_q[O+1], filt_q[O+1],
        use_sync[1], use_filt[1],
        s2_q[O+1]);
      assign cond[O] = pick(s2_q[O], filt_q[O],
        use_sync[0], use_filt[0],
        s2_q[O]);
    end
  endgenerate

  // ****************************************
  // decoder 0
  // ****************************************
  qdi_decoder #(.POS_W(POS_W)) u_dec0 (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .run_in         (run_q),
    .pins_in        (cond[3:0]),
    .cmp_val_in     (cmp0_in),
    .pos_out        (pos0_out),
    .phase_err_out  (phase_err_out[0]),
    .cmp_sync_out   (cmp_sync_out[0]),
    .index_seen_out (index_seen_out[0]),
    .strobe_pos_out (strobe_pos0_out)
  );

  // ****************************************
  // decoder 1
  // ****************************************
  qdi_decoder #(.POS_W(POS_W)) u_dec1 (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .run_in         (run_q),
    .pins_in        (cond[7:4]),
    .cmp_val_in     (cmp1_in),
    .pos_out        (pos1_out),
    .phase_err_out  (phase_err_out[1]),
    .cmp_sync_out   (cmp_sync_out[1]),
    .index_seen_out (index_seen_out[1]),
    .strobe_pos_out (strobe_pos1_out)
  );

  // ****************************************
  // error routing to timer
  // ****************************************
  logic err_mux;

  always_comb
  begin
    case (err_sel_in)
      1'b0:    err_mux = phase_err_out[0];
      1'b1:    err_mux = phase_err_out[1];
      default: err_mux = phase_err_out[0];
    endcase
  end

  // ****************************************
  // timer output
  // ****************************************
  // registered so the timer input never glitches
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      timer_err_n_out <= 1'b1;
    else
      timer_err_n_out <= ~err_mux;
  end

endmodule : qdi_top

/* bench/qdi_checker.sv */
`timescale 1ns/1ps
module qdi_checker
  import qdi_pkg::*;
#(
  parameter int POS_W  = QDI_POS_WIDTH,
  parameter int FILT_W = QDI_FILT_WIDTH
)(
  input wire logic             clk_in,          // bus clock
  input wire logic             srst_in,         // sync reset
  input wire logic [31:0]      clk_dis_in,      // disable word
  input wire logic [31:0]      path_sel_in,     // path select
  input wire logic             err_sel_in,      // error source
  input wire qdi_pins_type     enc0_in,         // encoder 0
  input wire logic [POS_W-1:0] cmp0_in,         // compare 0
  input wire logic [POS_W-1:0] pos0_out,        // position 0
  input wire logic [POS_W-1:0] pos1_out,        // position 1
  input wire logic [1:0]       phase_err_out,   // errors
  input wire logic [1:0]       cmp_sync_out,    // compare pulses
  input wire logic             timer_err_n_out, // to timer
  input wire logic             dec_run_out      // clock running
);
  localparam int LAT_S = QDI_CNT_LAT_CYC;
  localparam int LAT_F = QDI_CNT_LAT_CYC + FILT_W + 1;
  logic err_mux;
  logic gate;
  assign err_mux = err_sel_in ? phase_err_out[1] : phase_err_out[0];
  assign gate    = clk_dis_in[QDI_CLK_GATE_BIT];
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // single legal step on phase a while running
  sequence a_edge_s;
    !gate && dec_run_out && $changed(enc0_in.phase_a)
      && $stable(enc0_in.phase_b);
  endsequence
  sequence gated_s;
    gate ##1 gate;
  endsequence
  reset_vals_a: assert property (disable iff (1'b0) srst_in |=>
    pos0_out == '0 && phase_err_out == 2'h0 && timer_err_n_out
      && dec_run_out) else $error("bad reset values");
  gate_off_a: assert property (gate |=> !dec_run_out)
    else $error("decoder clock not gated");
  gate_on_a: assert property (!gate |=> dec_run_out)
    else $error("decoder clock not running");
  frozen_pos_a: assert property (gated_s |=>
    $stable(pos0_out) && $stable(pos1_out)) else $error("gated moved");
  err_set_a: assert property (err_mux |=> !timer_err_n_out)
    else $error("error not forwarded");
  err_clr_a: assert property (!err_mux |=> timer_err_n_out)
    else $error("wrong error source");
  sync_lat_a: assert property (a_edge_s and path_sel_in[0]
    |-> ##[1:LAT_S] $changed(pos0_out)) else $error("sync count late");
  filt_lat_a: assert property (a_edge_s and path_sel_in[1:0] == 2'h2
    |-> ##[1:LAT_F] $changed(pos0_out)) else $error("filt count late");
  cmp_pos_a: assert property (cmp_sync_out[0] |->
    pos0_out == cmp0_in) else $error("compare pulse off value");
endmodule : qdi_checker

/* bench/qdi_enc_model.sv */
`timescale 1ns/1ps
module qdi_enc_model
  import qdi_pkg::*;
(
  input  wire logic   clk_in,  // bus clock
  output qdi_pins_type pins_out // encoder pins
);
  logic [1:0] ph = 2'h0;
  initial pins_out = '0;
  // inc 2 flips both phases, a deliberate fault
  task automatic move(input logic [1:0] inc, input int hold);
    @(posedge clk_in);
    #1;
    ph = ph + inc;
    pins_out.phase_a = ^ph;
    pins_out.phase_b = ph[1];
    repeat (hold) @(posedge clk_in);
    #1;
  endtask : move
  task automatic pulse(input int hold, input logic strobe);
    @(posedge clk_in);
    #1;
    pins_out.index  = !strobe;
    pins_out.strobe = strobe;
    repeat (hold) @(posedge clk_in);
    #1;
    pins_out.index  = 1'b0;
    pins_out.strobe = 1'b0;
    repeat (hold) @(posedge clk_in);
    #1;
  endtask : pulse
endmodule : qdi_enc_model

/* bench/qdi_top_test.sv */
`timescale 1ns/1ps
module qdi_top_test
  import qdi_pkg::*;
;
  logic clk_in = 1'b0, srst_in = 1'b1, err_sel_in = 1'b0, tmr, run;
  logic [31:0] clk_dis_in = 32'h0, path_sel_in = QDI_SEL_RESET;
  logic [31:0] p0, p1, sp0, sp1, cmp0 = 32'h3, cmp1 = 32'h1;
  logic [1:0] perr, csync, idx;
  qdi_pins_type e0, e1;
  int err_total, checked, cyc, hits, hits1;
  initial forever #20 clk_in = ~clk_in;
  qdi_enc_model m0 (.clk_in(clk_in), .pins_out(e0));
  qdi_enc_model m1 (.clk_in(clk_in), .pins_out(e1));
  qdi_top dut (.clk_in(clk_in), .srst_in(srst_in),
    .clk_dis_in(clk_dis_in), .path_sel_in(path_sel_in),
    .err_sel_in(err_sel_in), .enc0_in(e0), .enc1_in(e1),
    .cmp0_in(cmp0), .cmp1_in(cmp1), .pos0_out(p0), .pos1_out(p1),
    .phase_err_out(perr), .cmp_sync_out(csync), .index_seen_out(idx),
    .strobe_pos0_out(sp0), .strobe_pos1_out(sp1), .timer_err_n_out(tmr),
    .dec_run_out(run));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk_in)
  begin
    cyc++;
    hits += (csync[0] === 1'b1);
    hits1 += (csync[1] === 1'b1);
    if (cyc == 2000)
    begin
      err_total++;
      give_verdict;
    end
  end
  task automatic t_count;
    for (int i = 1; i <= 4; i++)
    begin
      m0.move(2'h1, 5);
      chk(p0, i);
    end
    chk(hits, 1);
  endtask : t_count
  task automatic t_error;
    err_sel_in = 1'b1;
    m1.move(2'h2, 5);
    chk(32'(perr), 32'h2);
    chk(p1, 0);
    chk(32'(tmr), 32'h0);
    err_sel_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk(32'(tmr), 32'h1);
    m1.move(2'h1, 5);
    chk(32'(perr), 32'h0);
    chk(hits1, 1);
    m1.pulse(5, 1'b1);
    chk(sp1, 32'h1);
  endtask : t_error
  task automatic t_gate;
    clk_dis_in[QDI_CLK_GATE_BIT] = 1'b1;
    m0.move(2'h1, 5);
    chk(32'(run), 32'h0);
    chk(p0, 32'h4);
    m0.move(2'h3, 5);
    chk(p0, 4);
    clk_dis_in = 32'h0;
    m0.move(2'h0, 5);
    chk(32'(run), 32'h1);
    chk(p0, 32'h4);
  endtask : t_gate
  task automatic t_filter;
    path_sel_in = 32'h0202_0202;
    m0.move(2'h1, 9);
    chk(p0, 5);
    m0.pulse(9, 1'b0);
    chk(32'(idx), 32'h1);
    m0.pulse(9, 1'b1);
    chk(sp0, 5);
  endtask : t_filter
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    chk(32'(perr), 32'h0);
    chk(32'(tmr), 32'h1);
    chk(32'(run), 32'h1);
    chk(p0, 32'h0);
    chk(p1, 32'h0);
    t_count;
    t_error;
    t_gate;
    t_filter;
    give_verdict;
  end
endmodule : qdi_top_test
bind qdi_top qdi_checker #(.POS_W(POS_W), .FILT_W(FILT_W)) u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .clk_dis_in(clk_dis_in),
  .path_sel_in(path_sel_in), .err_sel_in(err_sel_in),
  .enc0_in(enc0_in), .cmp0_in(cmp0_in), .pos0_out(pos0_out),
  .pos1_out(pos1_out), .phase_err_out(phase_err_out),
  .cmp_sync_out(cmp_sync_out), .timer_err_n_out(timer_err_n_out),
  .dec_run_out(dec_run_out));
